// >>> design/hcis_consts.svh
/*
  offsets, field positions, reset values and counts for the control channel
  interrupt status block; assumes an 8-bit register port with a 9-bit address.
*/
`ifndef HCIS_CONSTS_SVH
`define HCIS_CONSTS_SVH

// ==========================================================
// register offsets
`define HCIS_OFS_SUMMARY   9'h144
`define HCIS_OFS_EVENT     9'h145
`define HCIS_OFS_CTRL      9'h1f0
`define HCIS_OFS_MASK      9'h1f1
`define HCIS_OFS_RESULT    9'h1f2

// ==========================================================
// event flag bit positions
`define HCIS_BIT_TOTAL     7
`define HCIS_BIT_ACK       6
`define HCIS_BIT_FAULT     5
`define HCIS_BIT_COND      4
`define HCIS_BIT_ADONE     1
`define HCIS_BIT_AHALT     0
`define HCIS_EVENT_VALID   8'hf3

// ==========================================================
// control register fields
`define HCIS_BIT_RUN       0
`define HCIS_BIT_ARUN      1
`define HCIS_ACK_LSB       4

// ==========================================================
// reset values and counts
`define HCIS_RST_BYTE      8'h00
`define HCIS_RETRY_LIMIT   2'h3

`endif

// >>> design/hcis_pkg.sv
/*
  types of the control channel interrupt status block;
  assumes the constants header is compiled alongside.
*/
package hcis_pkg;

  typedef enum logic [4:0] {
    HCIS_IDLE  = 5'b00001,
    HCIS_SETUP = 5'b00010,
    HCIS_DATA  = 5'b00100,
    HCIS_STAT  = 5'b01000,
    HCIS_STOP  = 5'b10000
  } hcis_seq_type;

  typedef enum logic [1:0] {
    HCIS_STG_NONE  = 2'h0,
    HCIS_STG_SETUP = 2'h1,
    HCIS_STG_DATA  = 2'h2,
    HCIS_STG_STAT  = 2'h3
  } hcis_stage_type;

  typedef enum logic [2:0] {
    HCIS_RC_OK    = 3'h0,
    HCIS_RC_STALL = 3'h1,
    HCIS_RC_OVER  = 3'h2,
    HCIS_RC_UNDER = 3'h3,
    HCIS_RC_RETRY = 3'h4
  } hcis_result_type;

endpackage

// >>> design/hcis_top.sv
/*
  control channel interrupt status: event flags, result code, assist
  sequencer tracking, bulk channel summary bit and interrupt output.
  assumes a transfer engine that reports each transaction end as a one-cycle
  txn_done with its error indications, and a firmware register port with
  read data one cycle after the read strobe.
*/
// What this block does
// - summary bit0 = any enabled bulk flag
// - event flags clear on written one
// - bit7 set on transfer done cleanly
// - with assist, bit7 after all stages
// - bit6 set when ack target reached
// - with assist, ack counts data stage only
// - bit5 set on any retry-class error
// - bit4 on stall, overrun, underrun, three retries
// - clearing run sets bit4, keeps result
// - three-bit result code encoding
// - oversize packet or excess data is overrun
// - crc or stuffing error makes retry
// - short packet toggle mismatch is retry
// - short packet under total is underrun
// - timeout, crc, stuff, pid, toggle are retry
// - bit1 when assist stages all complete
// - stop during good status sets bit1
// - bit0 when assist aborts on error
`include "hcis_consts.svh"

module hcis_top
  import hcis_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] bulk_channel_event_flags,
  input  wire logic [7:0] bulk_channel_event_enables,
  input  wire logic       txn_done,
  input  wire logic       txn_busy,
  input  wire logic [1:0] txn_stage,
  input  wire logic       txn_timeout,
  input  wire logic       txn_crc_err,
  input  wire logic       txn_stuff_err,
  input  wire logic       txn_pid_chk_err,
  input  wire logic       txn_pid_undef,
  input  wire logic       txn_toggle_bad,
  input  wire logic       txn_stall,
  input  wire logic       txn_pkt_over_max,
  input  wire logic       txn_pkt_short,
  input  wire logic       txn_total_over,
  input  wire logic       txn_total_under,
  input  wire logic       xfer_complete,
  output logic            transfer_run,
  output logic            assist_run,
  output logic      [2:0] result_code,
  output logic            irq
);

  // ==========================================================
  // reset release
  logic rst_s1_reg;
  logic rst_b_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_reg <= 1'b0;
      rst_b_reg  <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_b_reg  <= rst_s1_reg;
    end
  end

  // ==========================================================
  // outcome classification
  function automatic hcis_result_type classify(
    input logic timeout, input logic crc, input logic stuff, input logic pidc,
    input logic pidu, input logic tog, input logic stall, input logic omax,
    input logic shrt, input logic tover, input logic tunder);
    // line errors dominate any size condition
    if (crc || stuff || timeout || pidc || pidu)
      classify = HCIS_RC_RETRY;
    else if (stall)
      classify = HCIS_RC_STALL;
    else if (tog && shrt)
      classify = HCIS_RC_RETRY;
    else if (omax || tover)
      classify = HCIS_RC_OVER;
    else if (shrt && tunder)
      classify = HCIS_RC_UNDER;
    else if (tog)
      classify = HCIS_RC_RETRY;
    else
      classify = HCIS_RC_OK;
  endfunction

  hcis_result_type outcome;
  logic            txn_ok;
  logic            txn_retry;
  logic            txn_cond;

  assign outcome = classify(txn_timeout, txn_crc_err, txn_stuff_err, txn_pid_chk_err,
                            txn_pid_undef, txn_toggle_bad, txn_stall, txn_pkt_over_max,
                            txn_pkt_short, txn_total_over, txn_total_under);
  assign txn_ok    = txn_done && (outcome == HCIS_RC_OK);
  assign txn_retry = txn_done && (outcome == HCIS_RC_RETRY);
  assign txn_cond  = txn_done && (outcome == HCIS_RC_STALL || outcome == HCIS_RC_OVER
                                  || outcome == HCIS_RC_UNDER);

  // ==========================================================
  // register writes
  logic       wr_event;
  logic       wr_ctrl;
  logic [7:0] ctrl_reg;
  logic [7:0] mask_reg;
  logic [3:0] ack_target;
  logic       run_cleared;
  logic       arun_set;
  logic       arun_cleared;

  assign wr_event     = reg_wr && reg_addr == `HCIS_OFS_EVENT;
  assign wr_ctrl      = reg_wr && reg_addr == `HCIS_OFS_CTRL;
  assign ack_target   = ctrl_reg[`HCIS_ACK_LSB +: 4];
  assign run_cleared  = wr_ctrl && ctrl_reg[`HCIS_BIT_RUN] && !reg_wdata[`HCIS_BIT_RUN];
  assign arun_set     = wr_ctrl && !ctrl_reg[`HCIS_BIT_ARUN] && reg_wdata[`HCIS_BIT_ARUN];
  assign arun_cleared = wr_ctrl && ctrl_reg[`HCIS_BIT_ARUN] && !reg_wdata[`HCIS_BIT_ARUN];
  assign transfer_run = ctrl_reg[`HCIS_BIT_RUN];
  assign assist_run   = ctrl_reg[`HCIS_BIT_ARUN];

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      ctrl_reg <= `HCIS_RST_BYTE;
    else if (wr_ctrl)
      ctrl_reg <= reg_wdata;
  end

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      mask_reg <= `HCIS_RST_BYTE;
    else if (reg_wr && reg_addr == `HCIS_OFS_MASK)
      mask_reg <= reg_wdata & `HCIS_EVENT_VALID;
  end

  // ==========================================================
  // result code: holds the last transaction outcome
  logic [2:0] result_reg;

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      result_reg <= 3'h0;
    else if (txn_done)
      result_reg <= outcome;
  end

  assign result_code = result_reg;

  // ==========================================================
  // consecutive retry counter
  logic [1:0] retry_cnt_reg;
  logic       retry_limit;

  assign retry_limit = txn_retry && (retry_cnt_reg + 2'h1 == `HCIS_RETRY_LIMIT);

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      retry_cnt_reg <= 2'h0;
    else if (txn_done)
      retry_cnt_reg <= (txn_retry && !retry_limit) ? retry_cnt_reg + 2'h1 : 2'h0;
  end

  // ==========================================================
  // assist sequencer tracking
  hcis_seq_type seq_reg;
  logic         assist_active;
  logic         seq_done;
  logic         seq_halt;
  logic         seq_abort;

  assign assist_active = seq_reg != HCIS_IDLE;
  // stall, size errors or retry exhaustion end the control transfer
  assign seq_abort     = txn_cond || retry_limit;

  always_comb
  begin
    seq_done = 1'b0;
    seq_halt = 1'b0;
    case (seq_reg)
      HCIS_SETUP, HCIS_DATA, HCIS_STAT:
      begin
        seq_halt = seq_abort;
        seq_done = txn_ok && txn_stage == HCIS_STG_STAT;
      end
      HCIS_STOP:
      begin
        // the stop ends with the transaction in flight, or at once if none
        if (txn_done)
        begin
          seq_done = txn_ok && txn_stage == HCIS_STG_STAT;
          seq_halt = !seq_done;
        end
        else if (!txn_busy)
          seq_halt = 1'b1;
      end
      default:
      begin
        seq_done = 1'b0;
        seq_halt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      seq_reg <= HCIS_IDLE;
    else
    begin
      case (seq_reg)
        HCIS_IDLE:
          if (arun_set)
            seq_reg <= HCIS_SETUP;
        HCIS_SETUP, HCIS_DATA, HCIS_STAT:
          if (seq_done || seq_halt)
            seq_reg <= HCIS_IDLE;
          else if (arun_cleared)
            seq_reg <= HCIS_STOP;
          else if (txn_ok && txn_stage == HCIS_STG_SETUP)
            seq_reg <= HCIS_DATA;
          else if (txn_done && txn_stage == HCIS_STG_STAT)
            seq_reg <= HCIS_STAT;
        HCIS_STOP:
          if (seq_done || seq_halt)
            seq_reg <= HCIS_IDLE;
        default:
          seq_reg <= HCIS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // ack target counter
  logic [3:0] ack_cnt_reg;
  logic       ack_count_en;
  logic       ack_hit;

  // outside the data stage the sequencer's transactions are not counted
  assign ack_count_en = txn_ok && (!assist_active || txn_stage == HCIS_STG_DATA);
  assign ack_hit      = ack_count_en && ack_target != 4'h0
                        && (ack_cnt_reg + 4'h1 == ack_target);

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      ack_cnt_reg <= 4'h0;
    else if (run_cleared || ack_hit)
      ack_cnt_reg <= 4'h0;
    else if (ack_count_en)
      ack_cnt_reg <= ack_cnt_reg + 4'h1;
  end

  // ==========================================================
  // event flags: a set in the clearing cycle wins
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  always_comb
  begin
    flag_set                  = 8'h00;
    flag_set[`HCIS_BIT_TOTAL] = assist_active ? seq_done : xfer_complete;
    flag_set[`HCIS_BIT_ACK]   = ack_hit;
    flag_set[`HCIS_BIT_FAULT] = txn_retry;
    flag_set[`HCIS_BIT_COND]  = txn_cond || retry_limit || run_cleared;
    flag_set[`HCIS_BIT_ADONE] = seq_done;
    flag_set[`HCIS_BIT_AHALT] = seq_halt;
  end

  assign flag_clr   = wr_event ? reg_wdata : 8'h00;
  assign flags_next = ((flags_reg & ~flag_clr) | flag_set) & `HCIS_EVENT_VALID;

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      flags_reg <= `HCIS_RST_BYTE;
    else
      flags_reg <= flags_next;
  end

  assign irq = |(flags_reg & mask_reg);

  // ==========================================================
  // read port
  logic summary_bit;

  assign summary_bit = |(bulk_channel_event_flags & bulk_channel_event_enables);

  always_ff @(posedge clk or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `HCIS_OFS_SUMMARY: reg_rdata <= {7'h00, summary_bit};
        `HCIS_OFS_EVENT:   reg_rdata <= flags_reg;
        `HCIS_OFS_CTRL:    reg_rdata <= ctrl_reg;
        `HCIS_OFS_MASK:    reg_rdata <= mask_reg;
        `HCIS_OFS_RESULT:  reg_rdata <= {5'h00, result_reg};
        default:           reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b_reg);

  summary_read_a: assert property (reg_rd && reg_addr == `HCIS_OFS_SUMMARY |=>
    reg_rdata == {7'h00, $past(summary_bit)}) else $error("summary bit wrong");
  flag_clear_a: assert property (wr_event && reg_wdata[`HCIS_BIT_FAULT] && !txn_retry |=>
    !flags_reg[`HCIS_BIT_FAULT]) else $error("flag not cleared");
  zero_write_keeps_a: assert property (wr_event && flags_reg[`HCIS_BIT_COND]
    && !reg_wdata[`HCIS_BIT_COND] |=> flags_reg[`HCIS_BIT_COND])
    else $error("flag lost on zero write");
  total_done_a: assert property (!assist_active && xfer_complete |=>
    flags_reg[`HCIS_BIT_TOTAL]) else $error("total flag missing");
  assist_total_a: assert property (assist_active && !seq_done |=>
    flags_reg[`HCIS_BIT_TOTAL] == $past(flags_reg[`HCIS_BIT_TOTAL]) || $past(wr_event))
    else $error("total flag set early");
  retry_fault_a: assert property (txn_done && txn_crc_err |=>
    flags_reg[`HCIS_BIT_FAULT] && result_code == HCIS_RC_RETRY)
    else $error("crc not retry");
  stall_cond_a: assert property (txn_done && txn_stall && !txn_crc_err && !txn_stuff_err
    && !txn_timeout && !txn_pid_chk_err && !txn_pid_undef |=>
    flags_reg[`HCIS_BIT_COND] && result_code == HCIS_RC_STALL)
    else $error("stall not reported");
  run_stop_a: assert property (run_cleared && !txn_done |=>
    flags_reg[`HCIS_BIT_COND] && $stable(result_code)) else $error("run clear wrong");
  short_toggle_a: assert property (txn_done && txn_toggle_bad && txn_pkt_short |=>
    result_code == HCIS_RC_RETRY) else $error("toggle mismatch misfiled");
  assist_halt_a: assert property (seq_halt |=> flags_reg[`HCIS_BIT_AHALT]
    && seq_reg == HCIS_IDLE) else $error("halt flag missing");
  reserved_zero_a: assert property (flags_reg[3:2] == 2'h0)
    else $error("reserved bits set");
  // a fault flag that is unmasked must reach the pin on the next cycle
  irq_level_a: assert property (txn_retry && mask_reg[`HCIS_BIT_FAULT]
    && !(reg_wr && reg_addr == `HCIS_OFS_MASK) |=> irq)
    else $error("irq mismatch");

  assist_ok_c: cover property (seq_reg == HCIS_STAT ##1 flags_reg[`HCIS_BIT_ADONE]);
  assist_stop_c: cover property (seq_reg == HCIS_STOP ##[1:20] seq_reg == HCIS_IDLE);
  retry3_c: cover property (retry_limit);
  ack_hit_c: cover property (ack_hit && assist_active);

endmodule

// >>> tb/hcis_txn_model.sv
/*
  stand-in for the channel transfer engine that faces the usb endpoints.
  assumes the bench calls one task at a time from a single process.
*/
module hcis_txn_model
(
  input  wire logic        clk,
  output logic             txn_done,
  output logic             txn_busy,
  output logic [1:0]       txn_stage,
  output logic [10:0]      txn_qual,
  output logic             xfer_complete
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle levels
  initial
  begin
    txn_done      = 1'b0;
    txn_busy      = 1'b0;
    txn_stage     = 2'h0;
    txn_qual      = 11'h000;
    xfer_complete = 1'b0;
  end

  // ==========================================================
  // transaction report
  // qualifier order: timeout crc stuff pidc pidu tog stall omax short tover tunder;
  // outside the pulse they flip, so a stale sample never looks valid
  task automatic send(input logic [1:0] stg, input logic [10:0] q, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    txn_done  <= 1'b1;
    txn_stage <= stg;
    txn_qual  <= q;
    @(posedge clk);
    txn_done  <= 1'b0;
    txn_stage <= ~stg;
    txn_qual  <= ~q;
  endtask

  task automatic finish_all();
    @(posedge clk);
    xfer_complete <= 1'b1;
    @(posedge clk);
    xfer_complete <= 1'b0;
  endtask

  task automatic set_busy(input logic b);
    @(posedge clk);
    txn_busy <= b;
  endtask
endmodule

// >>> tb/tb.sv
/*
  self-checking bench for the control channel interrupt status block.
  assumes the constants header and package are compiled first.
*/
`include "hcis_consts.svh"

module tb
  import hcis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic        clk;
  logic        rst_b;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  bulk_f;
  logic [7:0]  bulk_e;
  logic        txn_done;
  logic        txn_busy;
  logic [1:0]  txn_stage;
  logic [10:0] q;
  logic        xfer_complete;
  logic        transfer_run;
  logic        assist_run;
  logic [2:0]  result_code;
  logic        irq;
  logic [7:0]  rd_val;
  int          err_count;
  int          n_tests;

  always #10 clk = ~clk;

  hcis_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bulk_channel_event_flags(bulk_f), .bulk_channel_event_enables(bulk_e),
    .txn_done(txn_done), .txn_busy(txn_busy), .txn_stage(txn_stage),
    .txn_timeout(q[10]), .txn_crc_err(q[9]), .txn_stuff_err(q[8]),
    .txn_pid_chk_err(q[7]), .txn_pid_undef(q[6]), .txn_toggle_bad(q[5]),
    .txn_stall(q[4]), .txn_pkt_over_max(q[3]), .txn_pkt_short(q[2]),
    .txn_total_over(q[1]), .txn_total_under(q[0]), .xfer_complete(xfer_complete),
    .transfer_run(transfer_run), .assist_run(assist_run),
    .result_code(result_code), .irq(irq));

  hcis_txn_model u_eng (.clk(clk), .txn_done(txn_done), .txn_busy(txn_busy),
    .txn_stage(txn_stage), .txn_qual(q), .xfer_complete(xfer_complete));

  // ==========================================================
  // bus and compare tasks
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [8:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk8(rd_val, exp, what);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // clearing both run bits may raise flags of its own, so they are wiped unjudged
  task automatic idle();
    wr(`HCIS_OFS_CTRL, 8'h00);
    wr(`HCIS_OFS_EVENT, 8'hff);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rchk(`HCIS_OFS_EVENT, 8'h00, "event reset");
    rchk(`HCIS_OFS_RESULT, 8'h00, "result reset");
    chk1(irq, 1'b0, "irq reset");
    wr(`HCIS_OFS_MASK, 8'hff);
    rchk(`HCIS_OFS_MASK, 8'hf3, "mask reserved");
    wr(9'h0a0, 8'h5a);
    rchk(9'h0a0, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_codes();
    localparam logic [10:0] CQ [13] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040,
      11'h020, 11'h010, 11'h008, 11'h002, 11'h005, 11'h208, 11'h105, 11'h024};
    localparam logic [2:0] CR [13] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h1,
      3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4};
    wr(`HCIS_OFS_CTRL, 8'h01);
    for (int i = 0; i < 13; i++)
    begin
      u_eng.send(HCIS_STG_NONE, 11'h000, 0);
      u_eng.send(HCIS_STG_NONE, CQ[i], 0);
      rchk(`HCIS_OFS_RESULT, {5'h00, CR[i]}, "code");
      chk8({5'h00, result_code}, {5'h00, CR[i]}, "code pin");
      rchk(`HCIS_OFS_EVENT, (CR[i] == HCIS_RC_RETRY) ? 8'h20 : 8'h10, "flag");
      wr(`HCIS_OFS_EVENT, 8'hff);
    end
    u_eng.send(HCIS_STG_NONE, 11'h005, 0);
    wr(`HCIS_OFS_EVENT, 8'hff);
    wr(`HCIS_OFS_CTRL, 8'h00);
    rchk(`HCIS_OFS_EVENT, 8'h10, "run cleared");
    chk1(transfer_run, 1'b0, "run pin off");
    rchk(`HCIS_OFS_RESULT, {5'h00, HCIS_RC_UNDER}, "last code kept");
    idle();
    $display("test codes done");
  endtask

  task automatic t_retry3();
    wr(`HCIS_OFS_CTRL, 8'h01);
    u_eng.send(HCIS_STG_NONE, 11'h000, 0);
    u_eng.send(HCIS_STG_NONE, 11'h200, 0);
    u_eng.send(HCIS_STG_NONE, 11'h200, 2);
    rchk(`HCIS_OFS_EVENT, 8'h20, "two retries");
    chk1(transfer_run, 1'b1, "run pin on");
    u_eng.send(HCIS_STG_NONE, 11'h200, 0);
    rchk(`HCIS_OFS_EVENT, 8'h30, "three retries");
    wr(`HCIS_OFS_EVENT, 8'h00);
    rchk(`HCIS_OFS_EVENT, 8'h30, "zero write");
    wr(`HCIS_OFS_EVENT, 8'h10);
    rchk(`HCIS_OFS_EVENT, 8'h20, "one bit clear");
    idle();
    $display("test retry done");
  endtask

  task automatic t_ack();
    wr(`HCIS_OFS_CTRL, 8'h21);
    u_eng.send(HCIS_STG_NONE, 11'h000, 0);
    rchk(`HCIS_OFS_EVENT, 8'h00, "ack one");
    u_eng.send(HCIS_STG_NONE, 11'h000, 3);
    rchk(`HCIS_OFS_EVENT, 8'h40, "ack two");
    idle();
    wr(`HCIS_OFS_CTRL, 8'h01);
    u_eng.finish_all();
    rchk(`HCIS_OFS_EVENT, 8'h80, "total done");
    idle();
    $display("test ack done");
  endtask

  task automatic t_assist();
    wr(`HCIS_OFS_CTRL, 8'h23);
    u_eng.send(HCIS_STG_SETUP, 11'h000, 0);
    u_eng.send(HCIS_STG_DATA, 11'h000, 3);
    rchk(`HCIS_OFS_EVENT, 8'h00, "setup not counted");
    chk1(assist_run, 1'b1, "assist pin on");
    u_eng.send(HCIS_STG_DATA, 11'h000, 0);
    rchk(`HCIS_OFS_EVENT, 8'h40, "data counted");
    u_eng.send(HCIS_STG_STAT, 11'h000, 0);
    rchk(`HCIS_OFS_EVENT, 8'hc2, "assist done");
    idle();
    wr(`HCIS_OFS_CTRL, 8'h03);
    u_eng.send(HCIS_STG_SETUP, 11'h000, 0);
    u_eng.send(HCIS_STG_DATA, 11'h010, 0);
    rchk(`HCIS_OFS_EVENT, 8'h11, "assist abort");
    rchk(`HCIS_OFS_RESULT, {5'h00, HCIS_RC_STALL}, "abort code");
    idle();
    wr(`HCIS_OFS_CTRL, 8'h03);
    u_eng.send(HCIS_STG_SETUP, 11'h000, 0);
    u_eng.set_busy(1'b1);
    wr(`HCIS_OFS_CTRL, 8'h01);
    u_eng.send(HCIS_STG_STAT, 11'h000, 2);
    u_eng.set_busy(1'b0);
    rchk(`HCIS_OFS_EVENT, 8'h82, "stop in status");
    chk1(assist_run, 1'b0, "assist pin off");
    idle();
    wr(`HCIS_OFS_CTRL, 8'h03);
    u_eng.send(HCIS_STG_SETUP, 11'h000, 0);
    wr(`HCIS_OFS_CTRL, 8'h01);
    rchk(`HCIS_OFS_EVENT, 8'h01, "stop idle engine");
    idle();
    $display("test assist done");
  endtask

  task automatic t_irq();
    wr(`HCIS_OFS_MASK, 8'h20);
    u_eng.send(HCIS_STG_NONE, 11'h000, 0);
    u_eng.send(HCIS_STG_NONE, 11'h040, 0);
    settle();
    chk1(irq, 1'b1, "irq raised");
    wr(`HCIS_OFS_MASK, 8'h10);
    settle();
    chk1(irq, 1'b0, "irq masked");
    wr(`HCIS_OFS_MASK, 8'h20);
    wr(`HCIS_OFS_EVENT, 8'h20);
    settle();
    chk1(irq, 1'b0, "irq cleared");
    @(posedge clk);
    bulk_f <= 8'h10;
    bulk_e <= 8'hef;
    rchk(`HCIS_OFS_SUMMARY, 8'h00, "summary off");
    @(posedge clk);
    bulk_e <= 8'h10;
    rchk(`HCIS_OFS_SUMMARY, 8'h01, "summary on");
    @(posedge clk);
    bulk_f <= 8'h00;
    $display("test irq done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    clk       = 1'b0;
    rst_b     = 1'b0;
    reg_addr  = 9'h000;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    bulk_f    = 8'h00;
    bulk_e    = 8'h00;
    err_count = 0;
    n_tests   = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_codes();
    t_retry3();
    t_ack();
    t_assist();
    t_irq();
    end_sim();
  end

  // the run needs well under a thousand cycles
  initial
  begin
    #100us;
    err_count++;
    end_sim();
  end
endmodule
